// ===== inc/async_timer_pkg.sv
// Constants for the asynchronous timer register block
package async_timer_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] OFS_COUNT = 8'h00;
    localparam logic [7:0] OFS_COMPARE = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    // Bus and register widths
    localparam int AXI_ADDR_W = 8;
    localparam int REG_W = 8;
    // Holding channel indices
    localparam int CH_COUNT = 0;
    localparam int CH_COMPARE = 1;
    localparam int CH_CONTROL = 2;
    localparam int NUM_CH = 3;
    // Status register field positions
    localparam int BIT_ASYNC_SEL = 3;
    localparam int BIT_COUNT_BUSY = 2;
    localparam int BIT_COMPARE_BUSY = 1;
    localparam int BIT_CONTROL_BUSY = 0;
    // Control register field positions
    localparam int BIT_RUN = 0;
    localparam int BIT_OUT_MODE_LO = 4;
    localparam int BIT_OUT_MODE_HI = 5;
    // Output pin actions on a match
    localparam logic [1:0] OUT_NONE = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_CLEAR = 2'h2;
    localparam logic [1:0] OUT_SET = 2'h3;
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // Timing counts
    localparam logic [1:0] XFER_LAST_EDGE = 2'h1;
    localparam int FLAG_SYNC_CYCLES = 3;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : async_timer_pkg

// ===== design/async_timer_register_sync.sv
// 8-bit timer with crystal-clocked holding registers behind AXI4-Lite
//
// Operation
// - Count readable and writable at any time
// - Count write blocks match on next tick
// - Compare value against count every tick
// - Select bit picks bus clock or crystal
// - Count write sets busy until transferred
// - Compare write sets busy until transferred
// - Control write sets busy until transferred
// - Count reads its read register; compare and control read holding
// - Holding value lands after two crystal edges
// - Count, compare and control each have their own holding stage
// - Compare disabled while count/compare transfer pending
// - Interrupt logic rearms after one crystal cycle
// - Oscillator runs only in crystal mode and outside deep sleep
// - Wake starts on tick after condition
// - Count read register refreshed per crystal edge
// - Flags reach bus side three cycles later
// - Compare pin changes on the tick itself
`timescale 1ns/10ps
module async_timer_register_sync (
    input wire logic i_clk,
    input wire logic i_reset,
    // AXI4-Lite write address
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [async_timer_pkg::AXI_ADDR_W-1:0] i_s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    // AXI4-Lite write response
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    // AXI4-Lite read address
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [async_timer_pkg::AXI_ADDR_W-1:0] i_s_axi_araddr,
    // AXI4-Lite read data
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    // Crystal oscillator pin level
    input wire logic i_crystal_in_pin,
    // Light sleep (power-save or extended standby)
    input wire logic i_light_sleep,
    // Deep sleep (power-down or standby)
    input wire logic i_deep_sleep,
    // Timer outputs
    output logic o_compare_out_pin,
    output logic o_osc_enable,
    output logic o_compare_flag,
    output logic o_overflow_flag,
    output logic o_wake
);
    import async_timer_pkg::*;

    // Bus-side write capture
    logic aw_got_ff;
    logic w_got_ff;
    logic [AXI_ADDR_W-1:0] wr_addr_ff;
    logic [REG_W-1:0] wr_data_ff;
    logic wr_lane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    // Bus-side read answer
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Timer state
    logic async_sel_ff;
    logic [REG_W-1:0] counter_ff;
    logic [REG_W-1:0] compare_ff;
    logic [REG_W-1:0] control_ff;
    logic [REG_W-1:0] count_read_ff;
    logic block_match_ff;
    logic pin_ff;
    logic xtal_prev_ff;
    logic tick_d_ff;
    // Per-channel holding stage
    logic [REG_W-1:0] hold_ff [NUM_CH];
    logic [NUM_CH-1:0] busy_ff;
    logic [1:0] edge_cnt_ff [NUM_CH];
    // Flag synchronising pipelines
    logic [FLAG_SYNC_CYCLES-1:0] cmp_pipe_ff;
    logic [FLAG_SYNC_CYCLES-1:0] ovf_pipe_ff;
    // Wake handling
    logic wake_pend_ff;
    logic rearm_block_ff;
    logic wake_ff;

    // Decode of the pending write
    wire wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire wr_count = wr_fire & wr_lane_ff & (wr_addr_ff == OFS_COUNT);
    wire wr_compare = wr_fire & wr_lane_ff & (wr_addr_ff == OFS_COMPARE);
    wire wr_control = wr_fire & wr_lane_ff & (wr_addr_ff == OFS_CONTROL);
    wire wr_status = wr_fire & wr_lane_ff & (wr_addr_ff == OFS_STATUS);
    wire wr_mapped = (wr_addr_ff == OFS_COUNT) | (wr_addr_ff == OFS_COMPARE)
                   | (wr_addr_ff == OFS_CONTROL) | (wr_addr_ff == OFS_STATUS);
    wire [NUM_CH-1:0] wr_sel = {wr_control, wr_compare, wr_count};
    // Select bit change abandons pending transfers
    wire sel_change = wr_status & (wr_data_ff[BIT_ASYNC_SEL] != async_sel_ff);

    // Oscillator on only in crystal mode and outside deep sleep
    assign o_osc_enable = async_sel_ff & ~i_deep_sleep;
    // Rising crystal edge, only while the oscillator runs
    wire xtal_edge = o_osc_enable & i_crystal_in_pin & ~xtal_prev_ff;
    // Timer tick from bus clock or crystal
    wire tick = async_sel_ff ? xtal_edge : 1'b1;

    // Transfer from holding into destination
    logic [NUM_CH-1:0] apply;
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            // Async: second crystal edge; sync: at once
            apply[i] = async_sel_ff ? (busy_ff[i] & xtal_edge & (edge_cnt_ff[i] == XFER_LAST_EDGE))
                                    : wr_sel[i];
        end
    end

    // Timer behaviour selected by control
    wire running = control_ff[BIT_RUN];
    wire [1:0] out_mode = control_ff[BIT_OUT_MODE_HI:BIT_OUT_MODE_LO];
    // Match gated by count-write block and pending count/compare transfers
    wire match = tick & running & (counter_ff == compare_ff) & ~block_match_ff
               & ~busy_ff[CH_COUNT] & ~busy_ff[CH_COMPARE];
    wire overflow = tick & running & (counter_ff == 8'hff) & ~apply[CH_COUNT];
    // Read register refresh after each crystal edge
    wire read_refresh = async_sel_ff ? tick_d_ff : 1'b1;

    // Bus handshakes
    assign o_s_axi_awready = ~aw_got_ff & ~bvalid_ff;
    assign o_s_axi_wready = ~w_got_ff & ~bvalid_ff;
    assign o_s_axi_arready = ~rvalid_ff;
    assign o_s_axi_bvalid = bvalid_ff;
    assign o_s_axi_bresp = bresp_ff;
    assign o_s_axi_rvalid = rvalid_ff;
    assign o_s_axi_rdata = rdata_ff;
    assign o_s_axi_rresp = rresp_ff;

    // Read data selection
    wire [REG_W-1:0] status_view = {4'h0, async_sel_ff, busy_ff[CH_COUNT],
                                    busy_ff[CH_COMPARE], busy_ff[CH_CONTROL]};
    wire rd_count = (i_s_axi_araddr == OFS_COUNT);
    wire rd_compare = (i_s_axi_araddr == OFS_COMPARE);
    wire rd_control = (i_s_axi_araddr == OFS_CONTROL);
    wire rd_status = (i_s_axi_araddr == OFS_STATUS);
    wire rd_mapped = rd_count | rd_compare | rd_control | rd_status;
    wire [REG_W-1:0] rd_value = rd_count ? count_read_ff
                              : rd_compare ? hold_ff[CH_COMPARE]
                              : rd_control ? hold_ff[CH_CONTROL]
                              : rd_status ? status_view
                              : RST_REG;

    // Write address and data capture, in either order
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            wr_addr_ff <= '0;
            wr_data_ff <= RST_REG;
            wr_lane_ff <= 1'b0;
        end else if (wr_fire) begin
            // Both halves consumed
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
        end else begin
            if (i_s_axi_awvalid & o_s_axi_awready) begin
                aw_got_ff <= 1'b1;
                wr_addr_ff <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid & o_s_axi_wready) begin
                w_got_ff <= 1'b1;
                wr_data_ff <= i_s_axi_wdata[REG_W-1:0];
                wr_lane_ff <= i_s_axi_wstrb[0];
            end
        end
    end

    // Write response
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (i_s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read answer, one cycle after the address
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (i_s_axi_arvalid & o_s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h0, rd_value};
            rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (i_s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Clock select bit; busy bits ignore writes
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            async_sel_ff <= 1'b0;
        end else if (wr_status) begin
            async_sel_ff <= wr_data_ff[BIT_ASYNC_SEL];
        end
    end

    // Crystal edge history
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            xtal_prev_ff <= 1'b0;
            tick_d_ff <= 1'b0;
        end else begin
            xtal_prev_ff <= i_crystal_in_pin;
            tick_d_ff <= xtal_edge;
        end
    end

    // Independent holding stage per count, compare and control register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            busy_ff <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                hold_ff[i] <= RST_REG;
                edge_cnt_ff[i] <= 2'h0;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_sel[i]) begin
                    // New write restarts this channel only; write wins over clear
                    hold_ff[i] <= wr_data_ff;
                    busy_ff[i] <= async_sel_ff;
                    edge_cnt_ff[i] <= 2'h0;
                end else if (sel_change) begin
                    // Clock switch drops the transfer
                    busy_ff[i] <= 1'b0;
                    edge_cnt_ff[i] <= 2'h0;
                end else if (apply[i]) begin
                    busy_ff[i] <= 1'b0;
                    edge_cnt_ff[i] <= 2'h0;
                end else if (busy_ff[i] & xtal_edge) begin
                    edge_cnt_ff[i] <= edge_cnt_ff[i] + 2'h1;
                end
            end
        end
    end

    // Destination registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            compare_ff <= RST_REG;
            control_ff <= RST_REG;
        end else begin
            if (apply[CH_COMPARE]) begin
                // Sync mode lands the bus word itself; holding is loaded in the same edge
                compare_ff <= async_sel_ff ? hold_ff[CH_COMPARE] : wr_data_ff;
            end
            if (apply[CH_CONTROL]) begin
                control_ff <= async_sel_ff ? hold_ff[CH_CONTROL] : wr_data_ff;
            end
        end
    end

    // Counter: load beats increment
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            counter_ff <= RST_REG;
        end else if (apply[CH_COUNT]) begin
            counter_ff <= async_sel_ff ? hold_ff[CH_COUNT] : wr_data_ff;
        end else if (tick & running) begin
            counter_ff <= counter_ff + 8'h01;
        end
    end

    // Match block for one tick after a count load
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            block_match_ff <= 1'b0;
        end else if (apply[CH_COUNT]) begin
            block_match_ff <= 1'b1;
        end else if (tick) begin
            block_match_ff <= 1'b0;
        end
    end

    // Compare pin acts on the tick itself
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_ff <= 1'b0;
        end else if (match) begin
            case (out_mode)
                OUT_TOGGLE: pin_ff <= ~pin_ff;
                OUT_CLEAR: pin_ff <= 1'b0;
                OUT_SET: pin_ff <= 1'b1;
                default: pin_ff <= pin_ff;
            endcase
        end
    end
    assign o_compare_out_pin = pin_ff;

    // Count read register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            count_read_ff <= RST_REG;
        end else if (read_refresh) begin
            count_read_ff <= counter_ff;
        end
    end

    // Flag events delayed into the bus domain
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cmp_pipe_ff <= '0;
            ovf_pipe_ff <= '0;
        end else begin
            cmp_pipe_ff <= {cmp_pipe_ff[FLAG_SYNC_CYCLES-2:0], match};
            ovf_pipe_ff <= {ovf_pipe_ff[FLAG_SYNC_CYCLES-2:0], overflow};
        end
    end
    assign o_compare_flag = cmp_pipe_ff[FLAG_SYNC_CYCLES-1];
    assign o_overflow_flag = ovf_pipe_ff[FLAG_SYNC_CYCLES-1];

    // Wake request on the tick after the condition
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wake_pend_ff <= 1'b0;
            rearm_block_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= 1'b0;
            if (tick & wake_pend_ff) begin
                // Fire wake and hold off one crystal cycle
                wake_ff <= 1'b1;
                wake_pend_ff <= 1'b0;
                rearm_block_ff <= 1'b1;
            end else if (tick) begin
                rearm_block_ff <= 1'b0;
            end
            if (async_sel_ff & i_light_sleep & (match | overflow) & ~rearm_block_ff
                & ~wake_pend_ff) begin
                wake_pend_ff <= 1'b1;
            end
        end
    end
    assign o_wake = wake_ff;

endmodule : async_timer_register_sync

// ===== bench/async_timer_register_sync_monitor.sv
// Port-level checker for the asynchronous timer block
`timescale 1ns/10ps
module async_timer_register_sync_monitor (
    input logic i_clk,
    input logic i_reset,
    input logic i_s_axi_awvalid,
    input logic o_s_axi_awready,
    input logic i_s_axi_wvalid,
    input logic o_s_axi_wready,
    input logic o_s_axi_bvalid,
    input logic i_s_axi_bready,
    input logic [1:0] o_s_axi_bresp,
    input logic i_s_axi_arvalid,
    input logic o_s_axi_arready,
    input logic o_s_axi_rvalid,
    input logic i_s_axi_rready,
    input logic [31:0] o_s_axi_rdata,
    input logic i_deep_sleep,
    input logic o_osc_enable,
    input logic o_compare_out_pin,
    input logic o_compare_flag
);
    // One clock domain with its synchronous reset
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    // Address taken on each bus direction
    sequence s_rd_take;
        i_s_axi_arvalid && o_s_axi_arready;
    endsequence
    sequence s_wr_take;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    AST_RD_ANSWER: assert property (s_rd_take |=> o_s_axi_rvalid)
        else $error("read answer missing");
    AST_RD_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data not held");
    AST_RD_WIDTH: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
        else $error("read data above byte");
    AST_WR_ANSWER: assert property (s_wr_take |=> ##1 o_s_axi_bvalid)
        else $error("write answer missing");
    AST_WR_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response not held");
    AST_OSC_DEEP: assert property (i_deep_sleep |-> !o_osc_enable)
        else $error("oscillator on in deep sleep");
    AST_PIN_FLAG: assert property ($changed(o_compare_out_pin) |-> ##[1:5] o_compare_flag)
        else $error("pin moved without match flag");
    AST_FLAG_PULSE: assert property (o_compare_flag |=> !o_compare_flag)
        else $error("compare flag longer than one cycle");
endmodule : async_timer_register_sync_monitor

bind async_timer_register_sync async_timer_register_sync_monitor i_mon (
    .i_clk, .i_reset, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .i_deep_sleep, .o_osc_enable,
    .o_compare_out_pin, .o_compare_flag
);

// ===== bench/async_timer_register_sync_tb.sv
// Self-checking bench for the asynchronous timer block
`timescale 1ns/10ps
module async_timer_register_sync_tb;
    import async_timer_pkg::*;
    logic i_clk = 1'h0, i_reset = 1'h1, i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0;
    logic i_s_axi_bready = 1'h0, i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
    logic i_crystal_in_pin = 1'h0, xrun = 1'h0, i_light_sleep = 1'h0, i_deep_sleep = 1'h0;
    logic [7:0] i_s_axi_awaddr = 8'h0, i_s_axi_araddr = 8'h0;
    logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
    logic [3:0] i_s_axi_wstrb = 4'h1;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic o_compare_out_pin, o_osc_enable, o_compare_flag, o_overflow_flag, o_wake;
    int bad_count = 0, comparisons = 0, xdiv = 0;

    async_timer_register_sync i_async_timer_register_sync (
        .i_clk, .i_reset, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
        .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb, .o_s_axi_bvalid,
        .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr,
        .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp, .i_crystal_in_pin,
        .i_light_sleep, .i_deep_sleep, .o_compare_out_pin, .o_osc_enable, .o_compare_flag,
        .o_overflow_flag, .o_wake
    );

    always #12.5 i_clk = ~i_clk;
    // Crystal pin of 32 clocks per period, and the run limit
    always @(posedge i_clk) begin
        xdiv <= xdiv + 1;
        if (xrun && xdiv[3:0] == 4'hf) begin
            i_crystal_in_pin <= ~i_crystal_in_pin;
        end
        if (xdiv == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Bounded wait for a level, sampled away from the edge
    task automatic wait_hi(ref logic s, output int n);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (s !== 1'h1 && n < 2000);
    endtask : wait_hi

    // Crystal rising edges plus settling clocks
    task automatic xrise(int k);
        repeat (k) @(posedge i_crystal_in_pin);
        repeat (4) @(posedge i_clk);
    endtask : xrise

    task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er);
        logic ha, hw, hb;
        logic [1:0] r;
        @(posedge i_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= {24'h0, d};
        i_s_axi_awvalid <= 1'h1;
        i_s_axi_wvalid <= 1'h1;
        i_s_axi_bready <= 1'h1;
        do begin
            @(negedge i_clk);
            ha = i_s_axi_awvalid & o_s_axi_awready;
            hw = i_s_axi_wvalid & o_s_axi_wready;
            hb = o_s_axi_bvalid;
            r = o_s_axi_bresp;
            @(posedge i_clk);
            if (ha) i_s_axi_awvalid <= 1'h0;
            if (hw) i_s_axi_wvalid <= 1'h0;
        end while (hb !== 1'h1);
        i_s_axi_bready <= 1'h0;
        check("bresp", r, er);
    endtask : wr

    task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        @(posedge i_clk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'h1;
        i_s_axi_rready <= 1'h1;
        do begin
            @(negedge i_clk);
            ha = i_s_axi_arvalid & o_s_axi_arready;
            hr = o_s_axi_rvalid;
            d = o_s_axi_rdata;
            r = o_s_axi_rresp;
            @(posedge i_clk);
            if (ha) i_s_axi_arvalid <= 1'h0;
        end while (hr !== 1'h1);
        i_s_axi_rready <= 1'h0;
    endtask : rd

    task automatic rc(string nm, logic [7:0] a, logic [7:0] e, logic [1:0] er = RESP_OKAY);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(nm, d, {24'h0, e});
        check("rresp", r, er);
    endtask : rc

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    initial begin
        logic [31:0] v;
        logic [1:0] r;
        logic p;
        int n;
        repeat (16) @(posedge i_clk);
        i_reset <= 1'h0;
        rc("count_rst", OFS_COUNT, 8'h00);
        rc("status_rst", OFS_STATUS, 8'h00);
        rc("unmapped_rd", 8'h10, 8'h00, RESP_SLVERR);
        wr(8'h10, 8'h55, RESP_SLVERR);
        $display("test reset done");
        // Bus-clock mode: read-back, strobe, read-only busy bits
        wr(OFS_COMPARE, 8'h40, RESP_OKAY);
        rc("compare_rd", OFS_COMPARE, 8'h40);
        wr(OFS_STATUS, 8'h07, RESP_OKAY);
        rc("busy_ro", OFS_STATUS, 8'h00);
        wr(OFS_COUNT, 8'h20, RESP_OKAY);
        rc("count_rd", OFS_COUNT, 8'h20);
        i_s_axi_wstrb <= 4'h0;
        wr(OFS_COUNT, 8'h99, RESP_OKAY);
        i_s_axi_wstrb <= 4'h1;
        rc("count_nostrb", OFS_COUNT, 8'h20);
        wr(OFS_COUNT, 8'h00, RESP_OKAY);
        // Every pin action on a running match
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CONTROL, {2'h0, m[1:0], 4'h1}, RESP_OKAY);
            repeat (8) @(posedge i_clk);
            p = o_compare_out_pin;
            wait_hi(o_compare_flag, n);
            check("flag_seen", n < 300, 1);
            check("pin", o_compare_out_pin, m == 0 ? p : m == 1 ? !p : m[0]);
        end
        // Running count wraps and raises the overflow flag
        wait_hi(o_overflow_flag, n);
        check("ovf_seen", n < 300, 1);
        // Loading the count masks the next tick's match
        wr(OFS_COUNT, 8'h40, RESP_OKAY);
        wait_hi(o_compare_flag, n);
        check("blocked_gap", n > 240 && n < 280, 1);
        $display("test sync done");
        // Crystal mode: busy flags and two-edge transfer
        wr(OFS_CONTROL, 8'h00, RESP_OKAY);
        xrun <= 1'h1;
        wr(OFS_STATUS, 8'h08, RESP_OKAY);
        check("osc_on", o_osc_enable, 1'h1);
        @(posedge i_crystal_in_pin);
        wr(OFS_COUNT, 8'h80, RESP_OKAY);
        wr(OFS_COMPARE, 8'h90, RESP_OKAY);
        rc("two_busy", OFS_STATUS, 8'h0e);
        xrise(1);
        rc("still_busy", OFS_STATUS, 8'h0e);
        xrise(1);
        rc("both_clear", OFS_STATUS, 8'h08);
        xrise(1);
        rc("count_async", OFS_COUNT, 8'h80);
        rc("compare_hold", OFS_COMPARE, 8'h90);
        wr(OFS_STATUS, 8'h0f, RESP_OKAY);
        rc("busy_ro_async", OFS_STATUS, 8'h08);
        wr(OFS_CONTROL, 8'h11, RESP_OKAY);
        rc("ctrl_busy", OFS_STATUS, 8'h09);
        xrise(2);
        rc("ctrl_clear", OFS_STATUS, 8'h08);
        // Light sleep: match wakes, count moves on first
        i_light_sleep <= 1'h1;
        wait_hi(o_wake, n);
        check("wake_seen", n < 1500, 1);
        @(posedge i_clk);
        i_light_sleep <= 1'h0;
        // Write, wait for busy to drop, then read the count
        wr(OFS_CONTROL, 8'h11, RESP_OKAY);
        xrise(2);
        rc("wake_ctrl_clear", OFS_STATUS, 8'h08);
        rd(OFS_COUNT, v, r);
        check("count_advanced", v[7:0] > 8'h90, 1);
        // Deep sleep stops the oscillator and the count
        xrise(1);
        i_deep_sleep <= 1'h1;
        rd(OFS_COUNT, v, r);
        xrise(2);
        rc("count_frozen", OFS_COUNT, v[7:0]);
        check("osc_off", o_osc_enable, 1'h0);
        $display("test async done");
        test_done();
    end
endmodule : async_timer_register_sync_tb
